/* src/ecd_clock_ctrl.sv */
// Function
// - Four independent dividers per edge clock set make slower clocks.
// - Each divider divides its input by two or by four.
// - Divided output phase is fixed by the release of the divider reset.
// - Divider input chosen from io cell, PLL or fabric clock.
// - Each divided clock drives out as a primary clock source.
// - Divider makes a local set/reset for the io cell gearing logic.
// - Selector drives one of two independent clocks out, chosen by select.
// - Selector output never glitches or shows runt pulses on a switch.
`timescale 1ns/1ns
`default_nettype none

module ecd_clock_ctrl
    import ecd_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     io_cell_clk,
    input  wire logic                     pll_clk,
    input  wire logic                     fabric_clk,
    input  wire logic [ECD_NUM_DIV-1:0]   div_hold,
    input  wire logic [ECD_NUM_DIV-1:0]   div_ratio,
    input  wire logic [2*ECD_NUM_DIV-1:0] div_src_sel,
    input  wire logic                     sel_clk_a,
    input  wire logic                     sel_clk_b,
    input  wire logic                     sel_choose_b,
    output logic      [ECD_NUM_DIV-1:0]   div_clk_out,
    output logic                          edge_local_set_reset,
    output logic                          global_clk_out
);

    logic [2:0]             src_meta_reg;
    logic [2:0]             src_sync_reg;
    logic [1:0]             sel_meta_reg;
    logic [1:0]             sel_sync_reg;
    logic [1:0]             sel_prev_reg;
    logic [ECD_NUM_DIV-1:0] lsr_bus;
    logic                   cur_b_reg;
    ecd_sel_state_e         sel_state_reg;
    logic                   cur_lvl;
    logic                   cur_fall;
    logic                   want_lvl;
    logic                   want_fall;
    logic                   leave_cur;
    logic                   join_new;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Falling edge of a synchronised clock: high last cycle, low now.
    // Used for both the followed and the requested selector clock.
    function automatic logic fall_seen
    (
        input logic prev_lvl,
        input logic now_lvl
    );
        return prev_lvl & ~now_lvl;
    endfunction : fall_seen

    // Level of clock a or clock b, as picked by one select bit.
    // Bit 0 of the pair is clock a and bit 1 is clock b.
    function automatic logic pick_clk
    (
        input logic [1:0] lvl,
        input logic       use_b
    );
        return use_b ? lvl[1] : lvl[0];
    endfunction : pick_clk

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Divider sources come from pins; two flops before any use.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            src_meta_reg <= 3'h0;
            src_sync_reg <= 3'h0;
        end
        else
        begin
            src_meta_reg <= {fabric_clk, pll_clk, io_cell_clk};
            src_sync_reg <= src_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Selector clock synchronisers
    // ------------------------------------------------------------------
    // Selector clocks are also foreign; synchronise, then keep a history
    // flop so that falling edges can be seen one cycle after they land.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sel_meta_reg <= 2'h0;
            sel_sync_reg <= 2'h0;
            sel_prev_reg <= 2'h0;
        end
        else
        begin
            sel_meta_reg <= {sel_clk_b, sel_clk_a};
            sel_sync_reg <= sel_meta_reg;
            sel_prev_reg <= sel_sync_reg;
        end
    end

    // ------------------------------------------------------------------
    // Divider bank
    // ------------------------------------------------------------------
    // One independent divider per lane, each with its own source and ratio.
    // All lanes share the same synchronised copies of the three sources.
    for (genvar i = 0; i < ECD_NUM_DIV; i++)
    begin : g_div
        ecd_divider u_div
        (
            .core_clk      (core_clk),
            .rst           (rst),
            .io_cell_clk_s (src_sync_reg[0]),
            .pll_clk_s     (src_sync_reg[1]),
            .fabric_clk_s  (src_sync_reg[2]),
            .src_sel       (div_src_sel[2*i +: 2]),
            .ratio         (div_ratio[i]),
            .div_hold      (div_hold[i]),
            .div_clk       (div_clk_out[i]),
            .lsr           (lsr_bus[i])
        );
    end

    // ------------------------------------------------------------------
    // Bank set/reset merge
    // ------------------------------------------------------------------
    // Gearing logic stays in reset while any divider lane still asks.
    // The merge is registered so the bank output comes from a flop.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            edge_local_set_reset <= 1'b1;
        else
            edge_local_set_reset <= |lsr_bus;
    end

    // ------------------------------------------------------------------
    // Glitch-free clock selector
    // ------------------------------------------------------------------
    // Levels and falling edges of the current and the requested clock.
    always_comb
    begin
        cur_lvl   = pick_clk(sel_sync_reg, cur_b_reg);
        cur_fall  = fall_seen(pick_clk(sel_prev_reg, cur_b_reg), cur_lvl);
        want_lvl  = pick_clk(sel_sync_reg, sel_choose_b);
        want_fall = fall_seen(pick_clk(sel_prev_reg, sel_choose_b), want_lvl);
    end

    // ------------------------------------------------------------------
    // Switch decisions
    // ------------------------------------------------------------------
    // The old clock is only left in its low phase and the new one only
    // joined at its fall, so no high pulse out is ever cut short.
    always_comb
    begin
        leave_cur = (sel_state_reg == ECD_SEL_RUN)
                    && (sel_choose_b != cur_b_reg)
                    && cur_fall;
        join_new  = (sel_state_reg == ECD_SEL_ARM)
                    && want_fall && !want_lvl;
    end

    // ------------------------------------------------------------------
    // Selector state and output
    // ------------------------------------------------------------------
    // Run while one clock is passed through; arm while waiting to join.
    // A stray state code falls back to arm, which keeps the output low.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            sel_state_reg <= ECD_SEL_ARM;
        else
        begin
            case (sel_state_reg)
                ECD_SEL_RUN:
                begin
                    if (leave_cur)
                        sel_state_reg <= ECD_SEL_ARM;
                end
                ECD_SEL_ARM:
                begin
                    if (join_new)
                        sel_state_reg <= ECD_SEL_RUN;
                end
                default:
                begin
                    sel_state_reg <= ECD_SEL_ARM;
                end
            endcase
        end
    end

    // The followed clock tracks the select while armed and at a leave.
    // A select change while armed only retargets the wait.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cur_b_reg <= 1'b0;
        else if (leave_cur || sel_state_reg == ECD_SEL_ARM)
            cur_b_reg <= sel_choose_b;
    end

    // Output copies the followed clock while running and is low otherwise,
    // so each pulse out is a whole pulse of one input.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            global_clk_out <= 1'b0;
        else if (sel_state_reg == ECD_SEL_RUN && !leave_cur)
            global_clk_out <= cur_lvl;
        else
            global_clk_out <= 1'b0;
    end

endmodule : ecd_clock_ctrl

`default_nettype wire

/* src/ecd_pkg.sv */
`default_nettype none

package ecd_pkg;

    // ------------------------------------------------------------------
    // Divider bank shape and ratio encodings
    // ------------------------------------------------------------------
    localparam int          ECD_NUM_DIV        = 4;
    localparam logic        HALF_RATE_RATIO    = 1'b0;
    localparam logic        QUARTER_RATE_RATIO = 1'b1;

    // ------------------------------------------------------------------
    // Divider source selection codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  SRC_IO_CELL        = 2'h0;
    localparam logic [1:0]  SRC_PLL            = 2'h1;
    localparam logic [1:0]  SRC_FABRIC         = 2'h2;

    // ------------------------------------------------------------------
    // Timing counts, in source clock edges
    // ------------------------------------------------------------------
    localparam logic [2:0]  LSR_HOLD_EDGES     = 3'h4;
    localparam logic [2:0]  LSR_CNT_RESET      = 3'h0;

    // ------------------------------------------------------------------
    // Selector state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ECD_SEL_ARM,
        ECD_SEL_RUN
    } ecd_sel_state_e;

endpackage : ecd_pkg

`default_nettype wire

/* src/ecd_divider.sv */
`timescale 1ns/1ns
`default_nettype none

module ecd_divider
    import ecd_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       io_cell_clk_s,
    input  wire logic       pll_clk_s,
    input  wire logic       fabric_clk_s,
    input  wire logic [1:0] src_sel,
    input  wire logic       ratio,
    input  wire logic       div_hold,
    output logic            div_clk,
    output logic            lsr
);

    logic       src_lvl;
    logic       src_prev_reg;
    logic       src_rise;
    logic       quarter_ph_reg;
    logic [2:0] lsr_cnt_reg;
    logic [2:0] lsr_cnt_next;

    // ------------------------------------------------------------------
    // Source selection and edge detection
    // ------------------------------------------------------------------
    // Picks the clock feeding this divider; unknown codes fall to fabric.
    always_comb
    begin
        case (src_sel)
            SRC_IO_CELL: src_lvl = io_cell_clk_s;
            SRC_PLL:     src_lvl = pll_clk_s;
            default:     src_lvl = fabric_clk_s;
        endcase
    end

    // Remembers the last source level so rising edges can be seen.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            src_prev_reg <= 1'b0;
        else
            src_prev_reg <= src_lvl;
    end

    assign src_rise = src_lvl & ~src_prev_reg;

    // ------------------------------------------------------------------
    // Divided clock
    // ------------------------------------------------------------------
    // Output sits low while held, so the first source rise after release
    // always starts the first high phase at a known alignment.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            div_clk        <= 1'b0;
            quarter_ph_reg <= 1'b0;
        end
        else if (div_hold)
        begin
            div_clk        <= 1'b0;
            quarter_ph_reg <= 1'b0;
        end
        else if (src_rise)
        begin
            quarter_ph_reg <= ~quarter_ph_reg;
            if (ratio == HALF_RATE_RATIO)
                div_clk <= ~div_clk;
            else if (!quarter_ph_reg)
                div_clk <= ~div_clk;
        end
    end

    // ------------------------------------------------------------------
    // Local set/reset for the gearing logic
    // ------------------------------------------------------------------
    // Next set/reset edge count, shared by the counter and its compare.
    assign lsr_cnt_next = lsr_cnt_reg + 3'h1;

    // Held active during the divider hold and for a few source edges after,
    // so gearing flops leave reset in step with the divided clock.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            lsr         <= 1'b1;
            lsr_cnt_reg <= LSR_CNT_RESET;
        end
        else if (div_hold)
        begin
            lsr         <= 1'b1;
            lsr_cnt_reg <= LSR_CNT_RESET;
        end
        else if (src_rise && lsr)
        begin
            lsr_cnt_reg <= lsr_cnt_next;
            if (lsr_cnt_next == LSR_HOLD_EDGES)
                lsr <= 1'b0;
        end
    end

endmodule : ecd_divider

`default_nettype wire

/* sim/ecd_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module ecd_checker
    import ecd_pkg::*;
(
    input wire logic                   core_clk,
    input wire logic                   rst,
    input wire logic [ECD_NUM_DIV-1:0] div_hold,
    input wire logic                   sel_choose_b,
    input wire logic [ECD_NUM_DIV-1:0] div_clk_out,
    input wire logic                   edge_local_set_reset,
    input wire logic                   global_clk_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [7:0] lsr_wait;
    // Counts cycles the set/reset stays up after every lane is released.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            lsr_wait <= 8'h00;
        else if (|div_hold || !edge_local_set_reset)
            lsr_wait <= 8'h00;
        else if (lsr_wait != 8'hff)
            lsr_wait <= lsr_wait + 8'h01;
    end
    a_reset_state: assert property (
        $past(rst) |-> edge_local_set_reset && !global_clk_out
        && div_clk_out == '0) else $error("bad state after reset");
    a_lsr_release: assert property (
        $fell(edge_local_set_reset) |-> $past(div_hold) == '0
        && $past(div_hold, 8) == '0) else $error("set/reset dropped early");
    a_lsr_bound: assert property (lsr_wait < 8'h78)
        else $error("set/reset never dropped");
    a_glob_high: assert property (
        $rose(global_clk_out) |=> global_clk_out [*3])
        else $error("runt high pulse on selector output");
    a_glob_low: assert property (
        $fell(global_clk_out) |=> !global_clk_out [*3])
        else $error("glitch low on selector output");
    for (genvar i = 0; i < ECD_NUM_DIV; i++)
    begin : g_lane
        a_hold_low: assert property (
            $past(div_hold[i]) |-> !div_clk_out[i])
            else $error("divided clock high while held");
        a_div_width: assert property (
            disable iff (rst || div_hold[i])
            $rose(div_clk_out[i]) |=> div_clk_out[i] [*3])
            else $error("divided clock pulse too short");
    end
    cover property ($fell(edge_local_set_reset));
    cover property ($rose(sel_choose_b) ##[1:60] $rose(global_clk_out));
    cover property ($fell(div_hold[0]) ##[1:40] $rose(div_clk_out[0]));
endmodule : ecd_checker
`default_nettype wire

/* sim/ecd_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module ecd_partner (
    output logic io_cell_clk,
    output logic pll_clk,
    output logic fabric_clk,
    output logic sel_clk_a,
    output logic sel_clk_b
);
    // Free-running slow clocks, offset so no edge meets a core clock edge.
    initial
    begin
        {io_cell_clk, pll_clk, fabric_clk, sel_clk_a, sel_clk_b} = 5'h00;
        #13;
        fork
            forever #200 io_cell_clk = ~io_cell_clk;
            forever #280 pll_clk = ~pll_clk;
            forever #360 fabric_clk = ~fabric_clk;
            forever #240 sel_clk_a = ~sel_clk_a;
            forever #320 sel_clk_b = ~sel_clk_b;
        join
    end
endmodule : ecd_partner
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb
    import ecd_pkg::*;
;
    logic core_clk, rst, io_cell_clk, pll_clk, fabric_clk;
    logic sel_clk_a, sel_clk_b, sel_choose_b, edge_local_set_reset;
    logic global_clk_out;
    logic [ECD_NUM_DIV-1:0] div_hold, div_ratio, div_clk_out;
    logic [2*ECD_NUM_DIV-1:0] div_src_sel;
    int fail_count = 0, checks = 0, cycles = 0, n, w;
    int src_p[4] = '{10, 14, 18, 18};

    ecd_partner u_far (.io_cell_clk(io_cell_clk), .pll_clk(pll_clk),
        .fabric_clk(fabric_clk), .sel_clk_a(sel_clk_a), .sel_clk_b(sel_clk_b));
    ecd_clock_ctrl DUT (.core_clk(core_clk), .rst(rst),
        .io_cell_clk(io_cell_clk), .pll_clk(pll_clk), .fabric_clk(fabric_clk),
        .div_hold(div_hold), .div_ratio(div_ratio), .div_src_sel(div_src_sel),
        .sel_clk_a(sel_clk_a), .sel_clk_b(sel_clk_b),
        .sel_choose_b(sel_choose_b), .div_clk_out(div_clk_out),
        .edge_local_set_reset(edge_local_set_reset),
        .global_clk_out(global_clk_out));

    // Core clock and a cycle ceiling against hangs.
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    task automatic step(input int k = 1);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : step

    function automatic logic pick(input int k);
        return (k < ECD_NUM_DIV) ? div_clk_out[k] : global_clk_out;
    endfunction : pick

    // Packs the set/reset, selector and divider outputs into one byte.
    function automatic logic [7:0] outs();
        return {2'h0, edge_local_set_reset, global_clk_out, div_clk_out};
    endfunction : outs

    // Lets a pulse already under way pass, then waits for a fresh rise
    // of one output and returns the wait and the whole high time.
    task automatic high_time(input int k, output int wt, output int hi);
        wt = 0;
        hi = 0;
        while (pick(k) === 1'b1 && hi < 200)
        begin
            step();
            hi++;
        end
        hi = 0;
        while (pick(k) !== 1'b1 && wt < 200)
        begin
            step();
            wt++;
        end
        while (pick(k) === 1'b1 && hi < 200)
        begin
            step();
            hi++;
        end
    endtask : high_time

    task automatic t_reset();
        step(8);
        chk(8'h20, outs());
        rst = 1'b0;
        step();
        chk(8'h20, outs());
        $display("reset test done");
    endtask : t_reset

    task automatic t_divide(input logic ratio);
        div_ratio = {ECD_NUM_DIV{ratio}};
        div_hold = 4'hf;
        step(3);
        div_hold = 4'h0;
        for (int k = 0; k < ECD_NUM_DIV; k++)
        begin
            high_time(k, w, n);
            if (k == 0)
                chk(8'h01, 8'(w <= src_p[0] + 4));
            chk(8'(ratio ? 2 * src_p[k] : src_p[k]), 8'(n));
        end
        $display("divide test done");
    endtask : t_divide

    task automatic t_lsr();
        div_hold = 4'hf;
        step(3);
        div_hold = 4'h8;
        step(150);
        chk(8'h01, {7'h00, edge_local_set_reset});
        chk(8'h00, {7'h00, div_clk_out[3]});
        div_hold = 4'h0;
        step(150);
        chk(8'h00, {7'h00, edge_local_set_reset});
        $display("set/reset test done");
    endtask : t_lsr

    task automatic t_select(input logic b, input int exp);
        sel_choose_b = b;
        step(3);
        sel_choose_b = ~b;
        step(2);
        sel_choose_b = b;
        step(40);
        high_time(4, w, n);
        chk(8'(exp), 8'(n));
        $display("select test done");
    endtask : t_select

    initial
    begin
        rst = 1'b1;
        div_hold = 4'hf;
        div_ratio = 4'h0;
        div_src_sel = 8'he4;
        sel_choose_b = 1'b0;
        #1;
        t_reset();
        t_divide(HALF_RATE_RATIO);
        t_divide(QUARTER_RATE_RATIO);
        t_lsr();
        t_select(1'b1, 8);
        t_select(1'b0, 6);
        end_of_test();
    end
endmodule : tb

bind ecd_clock_ctrl ecd_checker u_chk (.core_clk(core_clk), .rst(rst),
    .div_hold(div_hold), .sel_choose_b(sel_choose_b),
    .div_clk_out(div_clk_out), .edge_local_set_reset(edge_local_set_reset),
    .global_clk_out(global_clk_out));
`default_nettype wire
